// >>> hdl/sfst_framer.sv
// Packer of the non-safe status and violation submodules of the scanner telegram.
`default_nettype none
module sfst_framer
  import sfst_pkg::*;
(
  input wire logic CLK, // 20 MHz clock.
  input wire logic SYS_RST, // Asynchronous reset, active high.
  input wire logic SCAN_START, // Pulse in the cycle before the first beam of a scan.
  input wire logic SCAN_END, // Pulse after the last beam of a scan.
  input wire logic BEAM_VALID_A, // Beam of function one valid.
  input wire sfst_beam_t BEAM_A, // Beam data, function one.
  input wire logic BEAM_VALID_B, // Beam of function two valid.
  input wire sfst_beam_t BEAM_B, // Beam data, function two.
  input wire sfst_status_t STATUS_B, // Live status of function two.
  output logic [23:0] STATUS_B_BYTES, // Status submodule, byte 0 in bits 7:0.
  output sfst_vio_t VIO_A, // Violation submodule of function one.
  output sfst_vio_t VIO_B, // Violation submodule of function two.
  output logic UPDATE // One cycle pulse when all submodules refresh.
);

  sfst_state_t state_reg;
  sfst_vio_t acc_a_reg;
  sfst_vio_t acc_b_reg;
  logic pseen_a_reg, wseen_a_reg, pseen_b_reg, wseen_b_reg;

  // Clamps an angle into the reportable span.
  function automatic logic signed [15:0] clamp_angle(input logic signed [15:0] a);
    if (a < ANGLE_MIN) begin
      return ANGLE_MIN;
    end else if (a > ANGLE_MAX) begin
      return ANGLE_MAX;
    end
    return a;
  endfunction : clamp_angle

  // Clamps a distance to the given maximum.
  function automatic logic [15:0] clamp_dist(input logic [15:0] d, input logic [15:0] mx);
    return (d > mx) ? mx : d;
  endfunction : clamp_dist

  // Forces a pair number into 1..10; out of range reads as 0 (none).
  function automatic logic [3:0] pair_ok(input logic [3:0] p);
    return (p >= PAIR_MIN && p <= PAIR_MAX) ? p : 4'h0;
  endfunction : pair_ok

  // Packs the three status bytes with reserved bits forced to zero.
  function automatic logic [23:0] pack_status(input sfst_status_t s);
    logic [23:0] b;
    b = STATUS_RESET;
    b[BIT_ACTIVE] = s.active;
    b[BIT_WARN_FREE] = s.active & s.warn_free;
    b[BIT_PROT_FREE] = s.active & s.prot_free;
    b[BIT_WSEG1] = s.warn_seg1_free;
    b[BIT_WSEG2] = s.warn_seg2_free;
    b[BIT_PSEG1] = s.prot_seg1_free;
    b[BIT_PSEG2] = s.prot_seg2_free;
    b[11:8] = pair_ok(s.pair1);
    b[15:12] = pair_ok(s.pair2);
    b[19:16] = pair_ok(s.pair3);
    b[16 + BIT_MATCH1] = s.match_one;
    b[16 + BIT_MATCH2] = s.match_two;
    return b;
  endfunction : pack_status

  // Scan sequencer: idle until a scan starts, latch after it ends.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= SFST_IDLE;
    end else begin
      case (state_reg)
        SFST_IDLE: begin
          if (SCAN_START) begin
            state_reg <= SFST_SCAN;
          end
        end
        SFST_SCAN: begin
          if (SCAN_END) begin
            state_reg <= SFST_LATCH;
          end
        end
        SFST_LATCH: begin
          state_reg <= SCAN_START ? SFST_SCAN : SFST_IDLE;
        end
        default: begin
          state_reg <= SFST_IDLE;
        end
      endcase
    end
  end

  wire logic scanning = (state_reg == SFST_SCAN);
  wire logic restart = SCAN_START && (state_reg != SFST_SCAN);

  // Function one accumulator keeps the first hit of each field in rotation order.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      acc_a_reg <= VIO_RESET;
      pseen_a_reg <= 1'b0;
      wseen_a_reg <= 1'b0;
    end else if (restart) begin
      acc_a_reg <= VIO_RESET;
      pseen_a_reg <= 1'b0;
      wseen_a_reg <= 1'b0;
    end else if (scanning && BEAM_VALID_A) begin
      if (BEAM_A.prot_hit && !pseen_a_reg) begin
        acc_a_reg.prot_angle <= clamp_angle(BEAM_A.angle);
        acc_a_reg.prot_distance <= clamp_dist(BEAM_A.distance, PROT_DIST_MAX);
        pseen_a_reg <= 1'b1;
      end
      if (BEAM_A.warn_hit && !wseen_a_reg) begin
        acc_a_reg.warn_angle <= clamp_angle(BEAM_A.angle);
        acc_a_reg.warn_distance <= clamp_dist(BEAM_A.distance, WARN_DIST_MAX);
        wseen_a_reg <= 1'b1;
      end
    end
  end

  // Function two accumulator, same layout.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      acc_b_reg <= VIO_RESET;
      pseen_b_reg <= 1'b0;
      wseen_b_reg <= 1'b0;
    end else if (restart) begin
      acc_b_reg <= VIO_RESET;
      pseen_b_reg <= 1'b0;
      wseen_b_reg <= 1'b0;
    end else if (scanning && BEAM_VALID_B) begin
      if (BEAM_B.prot_hit && !pseen_b_reg) begin
        acc_b_reg.prot_angle <= clamp_angle(BEAM_B.angle);
        acc_b_reg.prot_distance <= clamp_dist(BEAM_B.distance, PROT_DIST_MAX);
        pseen_b_reg <= 1'b1;
      end
      if (BEAM_B.warn_hit && !wseen_b_reg) begin
        acc_b_reg.warn_angle <= clamp_angle(BEAM_B.angle);
        acc_b_reg.warn_distance <= clamp_dist(BEAM_B.distance, WARN_DIST_MAX);
        wseen_b_reg <= 1'b1;
      end
    end
  end

  // All submodules publish together in the latch cycle.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      STATUS_B_BYTES <= STATUS_RESET;
      VIO_A <= VIO_RESET;
      VIO_B <= VIO_RESET;
      UPDATE <= 1'b0;
    end else begin
      UPDATE <= (state_reg == SFST_LATCH);
      if (state_reg == SFST_LATCH) begin
        STATUS_B_BYTES <= pack_status(STATUS_B);
        VIO_A <= acc_a_reg;
        VIO_B <= acc_b_reg;
      end
    end
  end

  // Checks on the published telegram content, the update pulse and the function one accumulator.
  chk_status_reserved: assert property (@(posedge CLK) disable iff (SYS_RST)
    STATUS_B_BYTES[7] == 1'b0 && STATUS_B_BYTES[21:20] == 2'b00)
    else $error("reserved status bits not zero");
  chk_free_needs_active: assert property (@(posedge CLK) disable iff (SYS_RST)
    !STATUS_B_BYTES[BIT_ACTIVE] |-> STATUS_B_BYTES[2:1] == 2'b00)
    else $error("field free while function off");
  chk_pair_range: assert property (@(posedge CLK) disable iff (SYS_RST)
    STATUS_B_BYTES[11:8] <= PAIR_MAX && STATUS_B_BYTES[15:12] <= PAIR_MAX
      && STATUS_B_BYTES[19:16] <= PAIR_MAX)
    else $error("pair number out of range");
  chk_angle_span: assert property (@(posedge CLK) disable iff (SYS_RST)
    VIO_A.prot_angle >= ANGLE_MIN && VIO_A.prot_angle <= ANGLE_MAX)
    else $error("protective angle out of span");
  chk_warn_angle: assert property (@(posedge CLK) disable iff (SYS_RST)
    VIO_A.warn_angle >= ANGLE_MIN && VIO_A.warn_angle <= ANGLE_MAX)
    else $error("warning angle out of span");
  chk_func_two_angle: assert property (@(posedge CLK) disable iff (SYS_RST)
    VIO_B.prot_angle >= ANGLE_MIN && VIO_B.prot_angle <= ANGLE_MAX
      && VIO_B.warn_angle >= ANGLE_MIN && VIO_B.warn_angle <= ANGLE_MAX)
    else $error("function two angle out of span");
  chk_prot_dist: assert property (@(posedge CLK) disable iff (SYS_RST)
    VIO_A.prot_distance <= PROT_DIST_MAX && VIO_B.prot_distance <= PROT_DIST_MAX)
    else $error("protective distance above limit");
  chk_warn_dist: assert property (@(posedge CLK) disable iff (SYS_RST)
    VIO_A.warn_distance <= WARN_DIST_MAX && VIO_B.warn_distance <= WARN_DIST_MAX)
    else $error("warning distance above limit");
  chk_stable_between: assert property (@(posedge CLK) disable iff (SYS_RST)
    !UPDATE ##1 !UPDATE |-> $stable(VIO_A) && $stable(VIO_B))
    else $error("violation data changed without update");
  chk_update_after_end: assert property (@(posedge CLK) disable iff (SYS_RST)
    (scanning && SCAN_END) |-> ##2 UPDATE)
    else $error("no update two cycles after scan end");
  chk_update_pulse: assert property (@(posedge CLK) disable iff (SYS_RST)
    UPDATE |=> !UPDATE)
    else $error("update pulse longer than one cycle");
  chk_latch_publish: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_reg == SFST_LATCH) |=> VIO_A == $past(acc_a_reg) && VIO_B == $past(acc_b_reg))
    else $error("violation data not taken from the finished scan");
  chk_first_hit_kept: assert property (@(posedge CLK) disable iff (SYS_RST)
    (scanning && BEAM_VALID_A && BEAM_A.prot_hit && pseen_a_reg && !restart)
      |=> $stable(acc_a_reg.prot_angle))
    else $error("later hit overwrote first hit");
  chk_status_copy: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_reg == SFST_LATCH) |=> STATUS_B_BYTES[0] == $past(STATUS_B.active))
    else $error("status not captured at latch");

  cov_scan_done: cover property (@(posedge CLK) disable iff (SYS_RST) UPDATE);
  cov_prot_hit: cover property (@(posedge CLK) disable iff (SYS_RST) UPDATE && VIO_A.prot_distance != 16'h0000);
  cov_back_to_back: cover property (@(posedge CLK) disable iff (SYS_RST) state_reg == SFST_LATCH && SCAN_START);
  cov_b_hit: cover property (@(posedge CLK) disable iff (SYS_RST) UPDATE && VIO_B.warn_distance != 16'h0000);

endmodule : sfst_framer
`default_nettype wire

// >>> shared/sfst_pkg.sv
// Package for the scanner field status telegram packer: layout, ids and limits.
`default_nettype none
package sfst_pkg;
  localparam int unsigned STAT_FIRST_BYTE = 17;
  localparam int unsigned STAT_LAST_BYTE = 19;
  localparam int unsigned VIO_FIRST_BYTE = 20;
  localparam logic [31:0] SUBMOD_STATUS_B = 32'h0000_0006;
  localparam logic [31:0] SUBMOD_VIO_A = 32'h0000_0007;
  localparam logic [31:0] SUBMOD_VIO_B = 32'h0000_0008;
  localparam int unsigned BIT_ACTIVE = 0;
  localparam int unsigned BIT_WARN_FREE = 1;
  localparam int unsigned BIT_PROT_FREE = 2;
  localparam int unsigned BIT_WSEG1 = 3;
  localparam int unsigned BIT_WSEG2 = 4;
  localparam int unsigned BIT_PSEG1 = 5;
  localparam int unsigned BIT_PSEG2 = 6;
  localparam int unsigned BIT_MATCH1 = 6;
  localparam int unsigned BIT_MATCH2 = 7;
  localparam logic [3:0] PAIR_MIN = 4'h1;
  localparam logic [3:0] PAIR_MAX = 4'hA;
  localparam logic signed [15:0] ANGLE_MIN = -16'sd135;
  localparam logic signed [15:0] ANGLE_MAX = 16'sd135;
  localparam logic [15:0] PROT_DIST_MAX = 16'h203A;
  localparam logic [15:0] WARN_DIST_MAX = 16'h4E20;
  localparam logic [23:0] STATUS_RESET = 24'h000000;
  localparam logic [63:0] VIO_RESET = 64'h0;

  // One beam of the scan as delivered by the measurement core.
  typedef struct packed {
    logic signed [15:0] angle;
    logic [15:0] distance;
    logic prot_hit;
    logic warn_hit;
  } sfst_beam_t;

  // Raw status inputs of the second protective function.
  typedef struct packed {
    logic active;
    logic warn_free;
    logic prot_free;
    logic warn_seg1_free;
    logic warn_seg2_free;
    logic prot_seg1_free;
    logic prot_seg2_free;
    logic [3:0] pair1;
    logic [3:0] pair2;
    logic [3:0] pair3;
    logic match_one;
    logic match_two;
  } sfst_status_t;

  // Violation module content, byte 0 first.
  typedef struct packed {
    logic signed [15:0] prot_angle;
    logic [15:0] prot_distance;
    logic signed [15:0] warn_angle;
    logic [15:0] warn_distance;
  } sfst_vio_t;

  typedef enum logic [1:0] {SFST_IDLE = 2'b00, SFST_SCAN = 2'b01, SFST_LATCH = 2'b11} sfst_state_t;
endpackage : sfst_pkg
`default_nettype wire

// >>> bench/sfst_reader.sv
// Fieldbus controller model that keeps a telegram image of the packer outputs.
`default_nettype none
module sfst_reader
  import sfst_pkg::*;
(
  input wire logic clk, // Scanner clock.
  input wire logic rst, // Reset, active high.
  input wire logic update, // Refresh pulse.
  input wire logic [23:0] stat, // Status bytes.
  input wire sfst_vio_t vio_a, // Violation module A.
  input wire sfst_vio_t vio_b, // Violation module B.
  output logic [87:0] image_a, // Telegram bytes 17 to 27.
  output sfst_vio_t image_b // Module B copy.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Take the image only on the refresh pulse, so it never mixes two scans.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      image_a <= '0;
      image_b <= '0;
    end else if (update) begin
      image_a <= {vio_a, stat};
      image_b <= vio_b;
    end
  end
endmodule : sfst_reader
`default_nettype wire

// >>> bench/sfst_framer_tb.sv
// Self-checking testbench of the status and violation packer.
`default_nettype none
module sfst_framer_tb
  import sfst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, start, stop, va, vb, upd;
  sfst_beam_t ba, bb;
  sfst_status_t st;
  logic [23:0] sb;
  sfst_vio_t oa, ob, ib;
  logic [87:0] ia;
  logic [63:0] ev [2];
  bit gp [2];
  bit gw [2];
  int err_count;
  int checks_done;
  int i;

  sfst_framer i_sfst_framer (.CLK(clk), .SYS_RST(rst), .SCAN_START(start), .SCAN_END(stop),
    .BEAM_VALID_A(va), .BEAM_A(ba), .BEAM_VALID_B(vb), .BEAM_B(bb), .STATUS_B(st),
    .STATUS_B_BYTES(sb), .VIO_A(oa), .VIO_B(ob), .UPDATE(upd));
  sfst_reader i_sfst_reader (.clk(clk), .rst(rst), .update(upd), .stat(sb), .vio_a(oa),
    .vio_b(ob), .image_a(ia), .image_b(ib));

  // The clock runs at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Compares one value and reports a mismatch.
  task automatic chk(string n, logic [63:0] s, logic [63:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // Limits a value to a range.
  function automatic logic [15:0] cl(int v, int lo, int hi);
    return 16'(v < lo ? lo : (v > hi ? hi : v));
  endfunction : cl

  // A pair number outside 1 to 10 is reported as zero.
  function automatic logic [3:0] pn(logic [3:0] p);
    return (p >= 4'h1 && p <= 4'hA) ? p : 4'h0;
  endfunction : pn

  function automatic logic [23:0] es(sfst_status_t s);
    return {s.match_two, s.match_one, 2'h0, pn(s.pair3), pn(s.pair2), pn(s.pair1), 1'b0,
      s.prot_seg2_free, s.prot_seg1_free, s.warn_seg2_free, s.warn_seg1_free,
      s.prot_free & s.active, s.warn_free & s.active, s.active};
  endfunction : es

  // Makes a random beam and keeps only the first hit of each field in the model.
  function automatic sfst_beam_t mk(int f, int h);
    int a;
    int d;
    logic p;
    logic w;
    a = int'($urandom_range(300)) - 150;
    d = $urandom_range(21000);
    p = (h != 0) && ($urandom_range(3) == 0);
    w = (h != 0) && ($urandom_range(3) == 0);
    if (p && !gp[f]) begin
      gp[f] = 1'b1;
      ev[f][63:32] = {cl(a, -135, 135), cl(d, 0, 8250)};
    end
    if (w && !gw[f]) begin
      gw[f] = 1'b1;
      ev[f][31:0] = {cl(a, -135, 135), cl(d, 0, 20000)};
    end
    return {16'(a), 16'(d), p, w};
  endfunction : mk

  // Runs one scan of n beams and checks the refreshed submodules; b2b starts the next scan in the latch cycle.
  task automatic scan(int n, int h, int b2b);
    int k;
    ev = '{64'h0, 64'h0};
    gp = '{0, 0};
    gw = '{0, 0};
    st = 21'($urandom);
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (n) begin
      va = 1'b1;
      vb = 1'b1;
      ba = mk(0, h);
      bb = mk(1, h);
      @(negedge clk);
    end
    va = 1'b0;
    vb = 1'b0;
    stop = 1'b1;
    @(negedge clk);
    stop = 1'b0;
    start = (b2b != 0);
    k = 1;
    while (upd !== 1'b1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    start = 1'b0;
    if (upd !== 1'b1) begin
      err_count++;
      end_of_test();
    end
    chk("latency", 64'(k), 64'h2);
    chk("status", 64'(sb), 64'(es(st)));
    chk("vio_a", oa, ev[0]);
    chk("vio_b", ob, ev[1]);
    st = ~st;
    repeat (3) @(negedge clk);
    chk("held", 64'(sb), 64'(es(~st)));
    chk("image_stat", 64'(ia[23:0]), 64'(sb));
    chk("image_a", ia[87:24], ev[0]);
    chk("image_b", ib, ev[1]);
  endtask : scan

  // Main sequence: reset, stray inputs while idle, then random scans.
  initial begin
    rst = 1'b1;
    {start, stop, va, vb} = 4'h0;
    ba = '0;
    bb = '0;
    st = '0;
    err_count = 0;
    checks_done = 0;
    void'($urandom(56));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk("rst_stat", 64'(sb), 64'h0);
    chk("rst_vio", oa | ob, 64'h0);
    stop = 1'b1;
    va = 1'b1;
    ba = {16'sh10, 16'h64, 1'b1, 1'b1};
    @(negedge clk);
    stop = 1'b0;
    va = 1'b0;
    repeat (3) @(negedge clk);
    chk("idle_upd", 64'(upd), 64'h0);
    scan(3, 0, 0);
    for (i = 0; i < 14; i++) begin
      scan($urandom_range(20, 1), 1, int'(i % 4 == 3));
    end
    end_of_test();
  end
endmodule : sfst_framer_tb
`default_nettype wire
